// >>> src/abu_pkg.sv
package abu_pkg;
    // ----------------------------------------
    // Widths and reset values
    // ----------------------------------------
    localparam int ADDR_W = 16;
    localparam logic [15:0] BRK_ADDR_RST = 16'h0000;
    localparam logic BRK_ENABLE_RST = 1'b0;
    localparam logic BRK_ACTIVE_RST = 1'b0;
    // ----------------------------------------
    // Vector addresses used by the partner
    // ----------------------------------------
    localparam logic [15:0] VEC_NORMAL = 16'hfffc;
    localparam logic [15:0] VEC_MONITOR = 16'hfefc;
    localparam logic [15:0] VEC_ADDR_RST = VEC_NORMAL;

    typedef enum logic [2:0] {
        ABU_IDLE = 3'b001,
        ABU_REQ = 3'b010,
        ABU_BREAK = 3'b100
    } abu_state_e;

    typedef struct packed {
        abu_state_e state;
        logic [15:0] brk_addr;
        logic break_enable_flag;
        logic break_active_flag;
        logic breakpoint_request;
        logic in_break;
        logic [15:0] vector_addr;
    } abu_regs_s;
endpackage : abu_pkg

// >>> src/abu_break_unit.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Address bus equal to stored break address raises the breakpoint request.
// - Break raised when program address matches full break address.
// - Writing one to the active flag raises a break regardless of address.
// - Return from interrupt in the break routine ends the break state.
// - Address breaks only with enable set; all 16 bits compared.
// - Active flag set on match; cleared by reset or software writing zero.
// - Opcode at break address does not execute until the routine completes.
module abu_break_unit (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic opcode_fetch_i,
    input wire logic monitor_mode_i,
    input wire logic vector_fetch_i,
    input wire logic rti_done_i,
    input wire logic cfg_wr_i,
    input wire logic [15:0] cfg_addr_i,
    input wire logic cfg_enable_i,
    input wire logic cfg_active_i,
    output logic breakpoint_request_o,
    output logic break_active_flag_o,
    output logic break_enable_flag_o,
    output logic in_break_o,
    output logic [15:0] vector_addr_o
);
    abu_pkg::abu_regs_s r;
    abu_pkg::abu_regs_s next_r;
    logic addr_hit;
    logic trig;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    // Shared by the sequencer and the checks so both agree on the vector choice
    function automatic logic [15:0] vec_for_mode(input logic mon);
        vec_for_mode = mon ? abu_pkg::VEC_MONITOR : abu_pkg::VEC_NORMAL;
    endfunction : vec_for_mode

    function automatic logic addr_match(input logic [15:0] bus_addr, input logic [15:0] stored, input logic en);
        addr_match = en && (bus_addr == stored);
    endfunction : addr_match

    // ----------------------------------------
    // Match and sequencing
    // ----------------------------------------
    // Operand fetches still match; only the opcode is held back by the partner.
    assign addr_hit = addr_match(cpu_addr_i, r.brk_addr, r.break_enable_flag);
    // Software break needs no enable and no match
    assign trig = addr_hit || (cfg_wr_i && cfg_active_i);

    always_comb begin
        next_r = r;
        if (cfg_wr_i) begin
            next_r.brk_addr = cfg_addr_i;
            next_r.break_enable_flag = cfg_enable_i;
            next_r.break_active_flag = cfg_active_i;
        end
        // Hardware set wins over a software clear in the same cycle
        if (addr_hit) begin
            next_r.break_active_flag = 1'b1;
        end
        case (r.state)
            abu_pkg::ABU_IDLE: begin
                if (trig) begin
                    next_r.state = abu_pkg::ABU_REQ;
                    next_r.breakpoint_request = 1'b1;
                    // Latched here so a mode change mid-break cannot move the vector
                    next_r.vector_addr = vec_for_mode(monitor_mode_i);
                end
            end
            abu_pkg::ABU_REQ: begin
                if (vector_fetch_i) begin
                    next_r.state = abu_pkg::ABU_BREAK;
                    next_r.breakpoint_request = 1'b0;
                    next_r.in_break = 1'b1;
                end
            end
            abu_pkg::ABU_BREAK: begin
                // Further matches are ignored until the routine returns
                if (rti_done_i) begin
                    next_r.state = abu_pkg::ABU_IDLE;
                    next_r.in_break = 1'b0;
                end
            end
            default: begin
                next_r.state = abu_pkg::ABU_IDLE;
                next_r.breakpoint_request = 1'b0;
                next_r.in_break = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r.state <= abu_pkg::ABU_IDLE;
            r.brk_addr <= abu_pkg::BRK_ADDR_RST;
            r.break_enable_flag <= abu_pkg::BRK_ENABLE_RST;
            r.break_active_flag <= abu_pkg::BRK_ACTIVE_RST;
            r.breakpoint_request <= 1'b0;
            r.in_break <= 1'b0;
            r.vector_addr <= abu_pkg::VEC_ADDR_RST;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign breakpoint_request_o = r.breakpoint_request;
    assign break_active_flag_o = r.break_active_flag;
    assign break_enable_flag_o = r.break_enable_flag;
    assign in_break_o = r.in_break;
    assign vector_addr_o = r.vector_addr;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_match_raises_req: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (addr_hit && r.state == abu_pkg::ABU_IDLE) |=> breakpoint_request_o)
        else $error("match did not raise request");
    a_match_sets_flag: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        addr_hit |=> break_active_flag_o)
        else $error("match did not set active flag");
    a_soft_break: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (cfg_wr_i && cfg_active_i && r.state == abu_pkg::ABU_IDLE) |=> breakpoint_request_o)
        else $error("software break lost");
    a_no_match_disabled: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (r.state == abu_pkg::ABU_IDLE && !r.break_enable_flag && !cfg_wr_i) |=> !breakpoint_request_o)
        else $error("break while disabled");
    a_req_held: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (breakpoint_request_o && !vector_fetch_i) |=> breakpoint_request_o)
        else $error("request dropped before ack");
    a_ack_drops_req: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (breakpoint_request_o && vector_fetch_i) |=> (!breakpoint_request_o && in_break_o))
        else $error("ack did not enter break");
    a_rti_ends: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (in_break_o && rti_done_i) |=> !in_break_o)
        else $error("return did not end break");
    a_vector_sel: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (r.state == abu_pkg::ABU_IDLE && addr_hit) |=> (vector_addr_o == vec_for_mode($past(monitor_mode_i))))
        else $error("wrong vector");

    // ----------------------------------------
    // Flag and configuration checks
    // ----------------------------------------
    a_soft_sets_flag: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (cfg_wr_i && cfg_active_i) |=> break_active_flag_o)
        else $error("software break did not set active flag");

    a_flag_soft_clear: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (cfg_wr_i && !cfg_active_i && !addr_hit) |=> !break_active_flag_o)
        else $error("active flag not cleared by write");

    a_flag_cause: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $rose(break_active_flag_o) |-> ($past(addr_hit) || ($past(cfg_wr_i) && $past(cfg_active_i))))
        else $error("active flag set without cause");

    a_enable_written: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        cfg_wr_i |=> (break_enable_flag_o == $past(cfg_enable_i)))
        else $error("enable not written");

    a_enable_by_write: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $changed(break_enable_flag_o) |-> $past(cfg_wr_i))
        else $error("enable changed without write");

    a_addr_written: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        cfg_wr_i |=> (r.brk_addr == $past(cfg_addr_i)))
        else $error("break address not written");

    // ----------------------------------------
    // Request handshake checks
    // ----------------------------------------
    a_req_cause: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $rose(breakpoint_request_o) |-> $past(trig))
        else $error("request raised without trigger");

    a_idle_quiet: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (!breakpoint_request_o && !in_break_o && !trig) |=> !breakpoint_request_o)
        else $error("request raised while idle");

    a_req_fall_ack: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $fell(breakpoint_request_o) |-> $past(vector_fetch_i))
        else $error("request dropped without ack");

    a_req_excl_break: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        breakpoint_request_o |-> !in_break_o)
        else $error("request during break");

    a_break_entry: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $rose(in_break_o) |-> $past(vector_fetch_i))
        else $error("break entered without vector fetch");

    a_break_exit: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $fell(in_break_o) |-> $past(rti_done_i))
        else $error("break left without return");

    // Matches during the routine must not stack a second break
    a_no_retrigger: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (in_break_o && !rti_done_i) |=> !breakpoint_request_o)
        else $error("break retriggered inside routine");

    // ----------------------------------------
    // Vector checks
    // ----------------------------------------
    a_vector_held: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (breakpoint_request_o || in_break_o) |=> $stable(vector_addr_o))
        else $error("vector moved during break");

    a_vector_mode: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $rose(breakpoint_request_o) |-> (vector_addr_o == vec_for_mode($past(monitor_mode_i))))
        else $error("vector does not follow mode");
endmodule : abu_break_unit

// >>> dv/abu_cpu_model.sv
`timescale 1ns/1ps
// ------------------------------
// CPU side answering break requests
// ------------------------------
module abu_cpu_model (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic req_i,
    input wire logic in_break_i,
    input wire logic [3:0] lat_i,
    output logic vf_o,
    output logic rti_o
);
    logic [3:0] cnt;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) {cnt, vf_o, rti_o} <= 6'h00;
        else begin
            cnt <= ((req_i && !vf_o) || (in_break_i && !rti_o)) ? cnt + 4'h1 : 4'h0;
            // Delay lat_i makes the answer prompt or slow
            vf_o <= req_i && !vf_o && cnt == lat_i;
            rti_o <= in_break_i && !req_i && !rti_o && cnt == lat_i;
        end
    end
endmodule : abu_cpu_model

// >>> dv/abu_break_unit_tb.sv
`timescale 1ns/1ps
module abu_break_unit_tb;
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, en = 1'b0, act = 1'b0, mon = 1'b0, hit, vf, return_from_interrupt_opcode, req, flag, inb, ena;
    logic [3:0] lat = 4'h0;
    logic [15:0] addr = 16'h0000, ca = 16'h0000, vec, break_unit;
    integer seed = 32'hd109c80d, err_count = 0, n_checks = 0, cyc = 0;
    initial forever #20 clk = ~clk;
    abu_break_unit abu_break_unit_i (.sys_clk_i(clk), .resetn_i(rstn), .cpu_addr_i(addr), .opcode_fetch_i(1'b1),
        .monitor_mode_i(mon), .vector_fetch_i(vf), .rti_done_i(return_from_interrupt_opcode), .cfg_wr_i(wr), .cfg_addr_i(ca),
        .cfg_enable_i(en), .cfg_active_i(act), .breakpoint_request_o(req), .break_active_flag_o(flag),
        .break_enable_flag_o(ena), .in_break_o(inb), .vector_addr_o(vec));
    abu_cpu_model abu_cpu_model_i (.clk_i(clk), .resetn_i(rstn), .req_i(req), .in_break_i(inb), .lat_i(lat),
        .vf_o(vf), .rti_o(return_from_interrupt_opcode));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) err_count++;
        if (got !== exp) $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    endtask : chk
    task automatic cfg(input logic e, input logic a);
        @(posedge clk);
        {wr, ca, en, act} <= {1'b1, break_unit, e, a};
        @(posedge clk);
        wr <= 1'b0;
    endtask : cfg
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) err_count++;
        if (cyc == 2000) close_out();
    end
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        #1 chk(vec, 16'hfffc);
        // Case 1 disabled, 2 near miss in top bit, 5 software break
        for (int i = 0; i < 8; i++) begin
            break_unit = 16'($random(seed));
            hit = i != 1 && i != 2;
            lat <= i[3:0];
            mon <= i[0];
            cfg(i != 1 && i != 5, i == 5);
            if (i != 5) begin
                addr <= i == 2 ? break_unit ^ 16'h8000 : break_unit;
                @(posedge clk);
                addr <= break_unit ^ 16'h0001;
            end
            #1 chk({15'h0, req}, {15'h0, hit});
            chk({15'h0, flag}, {15'h0, hit});
            chk({15'h0, ena}, {15'h0, i != 1 && i != 5});
            if (hit) chk(vec, i[0] ? abu_pkg::VEC_MONITOR : abu_pkg::VEC_NORMAL);
            for (int k = 0; k < 40 && (req || inb); k++) begin
                @(posedge clk);
                #1;
            end
            #1 chk({14'h0, req, inb}, 16'h0000);
            cfg(1'b0, 1'b0);
            #1 chk({15'h0, flag}, 16'h0000);
        end
        close_out();
    end
endmodule : abu_break_unit_tb
